// *** rtl/tlic_defs.svh ***
/*
 * Constants of the two-level interrupt controller: vectors, bit positions,
 * reset values and timing counts. Assumes inclusion by bare name.
 */
`ifndef TLIC_DEFS_SVH
`define TLIC_DEFS_SVH

`define TLIC_ADDR_W      21
`define TLIC_VEC_HIGH    21'h000008
`define TLIC_VEC_LOW     21'h000018
`define TLIC_N_EXT       3
`define TLIC_N_PER       8
`define TLIC_PRIO_BIT    7
`define TLIC_GH_BIT      7
`define TLIC_GL_BIT      6
`define TLIC_TMR_FLAG    0
`define TLIC_CTRL_RST    8'h00
`define TLIC_FLAG_RST    8'h00
`define TLIC_EXT_RST     3'h0
`define TLIC_CMP_TRIG    4'hB
`define TLIC_TMR_MAX     16'hFFFF
`define TLIC_TMR_RST     16'h0000
`define TLIC_LAT_PUSH    3
`define TLIC_LAT_LOAD    4

`endif

// *** rtl/tlic_pkg.sv ***
/*
 * Types shared by the interrupt controller files.
 * Assumes tlic_defs.svh is on the include path.
 */
`include "tlic_defs.svh"

package tlic_pkg;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_LOAD
    } tlic_state_t;

    // One core redirect: strobe and address
    typedef struct packed {
        logic                    strobe;
        logic [`TLIC_ADDR_W-1:0] addr;
    } tlic_redir_t;

endpackage : tlic_pkg

// *** rtl/tlic_edge.sv ***
/*
 * Rising-edge detector for the external event pins.
 * Assumes pins are synchronous to CLK.
 */
`timescale 1ns/1ns
`include "tlic_defs.svh"

module tlic_edge (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [`TLIC_N_EXT-1:0] pins,
    output logic      [`TLIC_N_EXT-1:0] rise
);
    logic [`TLIC_N_EXT-1:0] prev;
    logic [`TLIC_N_EXT-1:0] next_rise;

    genvar i;
    generate
        for (i = 0; i < `TLIC_N_EXT; i++) begin : g_pin
            always_comb begin
                next_rise[i] = pins[i] & ~prev[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev <= `TLIC_EXT_RST;
            rise <= `TLIC_EXT_RST;
        end else begin
            prev <= pins;
            rise <= next_rise;
        end
    end
endmodule : tlic_edge

// *** rtl/tlic_timer.sv ***
/*
 * 16-bit up counter with overflow pulse and compare-trigger reset.
 * Assumes write and trigger strobes are one-cycle pulses on CLK.
 */
`timescale 1ns/1ns
`include "tlic_defs.svh"

module tlic_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    input  wire logic [3:0]  cmp_mode,
    input  wire logic        cmp_match,
    output logic      [15:0] count,
    output logic             ovf
);
    logic [15:0] next_count;
    logic        next_ovf;
    logic        trig;

    always_comb begin
        trig       = cmp_match && (cmp_mode == `TLIC_CMP_TRIG);
        next_count = count;
        next_ovf   = 1'b0;
        if (wr) begin
            next_count = wdata;                           // [R18]
        end else if (trig) begin
            next_count = `TLIC_TMR_RST;                   // [R18]
        end else if (run) begin
            next_count = count + 16'h0001;                // [R16]
            next_ovf   = (count == `TLIC_TMR_MAX);        // [R16]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= `TLIC_TMR_RST;
            ovf   <= 1'b0;
        end else begin
            count <= next_count;
            ovf   <= next_ovf;
        end
    end

    trig_reset_a: assert property (@(posedge clk) disable iff (rst) // [R18]
        trig && !wr |=> count == `TLIC_TMR_RST && !ovf)
        else $error("compare trigger did not reset timer");
    wr_wins_a: assert property (@(posedge clk) disable iff (rst) // [R18]
        wr |=> count == $past(wdata))
        else $error("timer write lost");
endmodule : tlic_timer

// *** rtl/tlic_top.sv ***
/*
 * Two-level prioritized interrupt controller with a timer source.
 * Assumes the core pulses RETURN_FROM_IRQ and presents CORE_RET_ADDR.
 */
// Contract
// [R01] High vector 000008h, low vector 000018h
// [R02] Enabled high request preempts low handler
// [R03] Each source has flag, enable, priority
// [R04] Priority levels only when control bit 7 set
// [R05] Bit 7 gates high, bit 6 low
// [R06] Flag, enable, group enable set vectors immediately
// [R07] Compatibility: single vector, global and peripheral gates
// [R08] Acceptance clears the governing global enable
// [R09] Low requests wait during high handler
// [R10] Push return address, then load vector
// [R11] Software clears flags before re-enabling
// [R12] Return op exits and sets enable again; the code ignores a return op in ST_LOAD or in a cycle that accepts a request
// [R13] External event to vector in 3-4 cycles
// [R14] Flags set regardless of any enable
// [R15] No memory-to-memory moves on control registers
// [R16] Timer wraps FFFFh to 0000h, sets flag
// [R17] Peripheral enable bit 0 gates timer request
// [R18] Compare trigger resets timer, no flag
// [R19] Simultaneous high and low: high first
`timescale 1ns/1ns
`include "tlic_defs.svh"

module tlic_top (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    SYS_RST,
    // Control registers
    input  wire logic [7:0]              RESET_CONTROL_REG,
    input  wire logic                    CTRL_WR,
    input  wire logic [7:0]              CTRL_WDATA,
    output logic      [7:0]              IRQ_CONTROL_REG,
    // Peripheral sources
    input  wire logic [`TLIC_N_PER-1:1]  PERIPH_EVENT,
    input  wire logic [`TLIC_N_PER-1:0]  PERIPH_FLAG_CLR,
    input  wire logic [`TLIC_N_PER-1:0]  PERIPHERAL_ENABLE_REG_A,
    input  wire logic [`TLIC_N_PER-1:0]  PERIPHERAL_PRIORITY_REG_A,
    output logic      [`TLIC_N_PER-1:0]  PERIPHERAL_FLAG_REG_A,
    // External pins
    input  wire logic [`TLIC_N_EXT-1:0]  EXTERNAL_IRQ_PINS,
    input  wire logic [`TLIC_N_EXT-1:0]  EXT_FLAG_CLR,
    input  wire logic [`TLIC_N_EXT-1:0]  EXT_ENABLE,
    input  wire logic [`TLIC_N_EXT-1:0]  EXT_PRIORITY,
    output logic      [`TLIC_N_EXT-1:0]  EXT_FLAGS,
    // Timer
    input  wire logic                    TIMER_RUN,
    input  wire logic                    TIMER_WR,
    input  wire logic [15:0]             TIMER_WDATA,
    input  wire logic [3:0]              COMPARE_MODE_SELECT,
    input  wire logic                    COMPARE_MATCH,
    output logic      [15:0]             TIMER_COUNT,
    // Core sequencer
    input  wire logic                    RETURN_FROM_IRQ_OP,
    input  wire logic [`TLIC_ADDR_W-1:0] CORE_RET_ADDR,
    output logic                         STACK_PUSH,
    output logic      [`TLIC_ADDR_W-1:0] STACK_PUSH_ADDR,
    output logic                         VECTOR_LOAD,
    output logic      [`TLIC_ADDR_W-1:0] VECTOR_ADDR,
    output logic                         HIGH_ACTIVE,
    output logic                         LOW_ACTIVE
);
    logic [`TLIC_N_EXT-1:0] ext_rise;
    logic                   tmr_ovf;

    tlic_edge u_edge (
        .clk  (CLK),
        .rst  (SYS_RST),
        .pins (EXTERNAL_IRQ_PINS),
        .rise (ext_rise)
    );

    tlic_timer u_timer (
        .clk       (CLK),
        .rst       (SYS_RST),
        .run       (TIMER_RUN),
        .wr        (TIMER_WR),
        .wdata     (TIMER_WDATA),
        .cmp_mode  (COMPARE_MODE_SELECT),
        .cmp_match (COMPARE_MATCH),
        .count     (TIMER_COUNT),
        .ovf       (tmr_ovf)
    );

    // Flags
    logic [`TLIC_N_PER-1:0] next_per;
    logic [`TLIC_N_EXT-1:0] next_ext;

    always_comb begin
        next_per = (PERIPHERAL_FLAG_REG_A & ~PERIPH_FLAG_CLR)
                 | {PERIPH_EVENT, tmr_ovf};               // [R14] [R16]
        next_ext = (EXT_FLAGS & ~EXT_FLAG_CLR) | ext_rise; // [R13] [R14]
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PERIPHERAL_FLAG_REG_A <= `TLIC_FLAG_RST;
            EXT_FLAGS             <= `TLIC_EXT_RST;
        end else begin
            PERIPHERAL_FLAG_REG_A <= next_per;
            EXT_FLAGS             <= next_ext;
        end
    end

    // Request qualification
    logic                   prio_en;
    logic                   gh;
    logic                   gl;
    logic [`TLIC_N_PER-1:0] per_en;
    logic [`TLIC_N_EXT-1:0] ext_en;
    logic                   hi_any;
    logic                   lo_any;
    logic                   take_hi;
    logic                   take_lo;
    logic                   take_c;

    always_comb begin
        prio_en = RESET_CONTROL_REG[`TLIC_PRIO_BIT];       // [R04]
        gh     = IRQ_CONTROL_REG[`TLIC_GH_BIT];
        gl     = IRQ_CONTROL_REG[`TLIC_GL_BIT];
        per_en = PERIPHERAL_FLAG_REG_A                     // [R03] [R17]
               & PERIPHERAL_ENABLE_REG_A;
        ext_en = EXT_FLAGS & EXT_ENABLE;                   // [R03]
        hi_any = |(per_en & PERIPHERAL_PRIORITY_REG_A)
               | |(ext_en & EXT_PRIORITY);
        lo_any = |(per_en & ~PERIPHERAL_PRIORITY_REG_A)
               | |(ext_en & ~EXT_PRIORITY);
        take_hi = prio_en && gh && hi_any;                 // [R02] [R05]
        take_lo = prio_en && gl && lo_any && !HIGH_ACTIVE  // [R09]
               && !take_hi;                                // [R19]
        take_c  = !prio_en && gh
               && ((|ext_en) || (gl && (|per_en)));        // [R07]
    end

    // Handler sequencing
    tlic_pkg::tlic_state_t  state;
    tlic_pkg::tlic_state_t  next_state;
    tlic_pkg::tlic_redir_t  next_push;
    tlic_pkg::tlic_redir_t  next_load;
    logic [`TLIC_ADDR_W-1:0] pend_vec;
    logic [`TLIC_ADDR_W-1:0] next_pend_vec;
    logic [7:0]             next_ctrl;
    logic                   next_hi_act;
    logic                   next_lo_act;

    always_comb begin
        next_state    = state;
        next_pend_vec = pend_vec;
        next_push     = '{strobe: 1'b0, addr: STACK_PUSH_ADDR};
        next_load     = '{strobe: 1'b0, addr: VECTOR_ADDR};
        next_ctrl     = IRQ_CONTROL_REG;
        next_hi_act   = HIGH_ACTIVE;
        next_lo_act   = LOW_ACTIVE;
        if (CTRL_WR) begin
            next_ctrl[`TLIC_GH_BIT] = CTRL_WDATA[`TLIC_GH_BIT];
            next_ctrl[`TLIC_GL_BIT] = CTRL_WDATA[`TLIC_GL_BIT];
        end
        case (state)
            tlic_pkg::ST_RUN: begin
                if (take_hi || take_c) begin
                    next_push     = '{strobe: 1'b1,
                                      addr: CORE_RET_ADDR}; // [R10]
                    next_pend_vec = `TLIC_VEC_HIGH;        // [R01] [R06]
                    next_ctrl[`TLIC_GH_BIT] = 1'b0;        // [R08]
                    next_hi_act   = 1'b1;
                    next_state    = tlic_pkg::ST_LOAD;
                end else if (take_lo) begin
                    next_push     = '{strobe: 1'b1,
                                      addr: CORE_RET_ADDR}; // [R10]
                    next_pend_vec = `TLIC_VEC_LOW;         // [R01] [R06]
                    next_ctrl[`TLIC_GL_BIT] = 1'b0;        // [R08]
                    next_lo_act   = 1'b1;
                    next_state    = tlic_pkg::ST_LOAD;
                end else if (RETURN_FROM_IRQ_OP) begin
                    if (prio_en && !HIGH_ACTIVE && LOW_ACTIVE) begin
                        next_lo_act = 1'b0;
                        next_ctrl[`TLIC_GL_BIT] = 1'b1;    // [R12]
                    end else begin
                        next_hi_act = 1'b0;
                        next_ctrl[`TLIC_GH_BIT] = 1'b1;    // [R12]
                    end
                end
            end
            tlic_pkg::ST_LOAD: begin
                next_load  = '{strobe: 1'b1, addr: pend_vec}; // [R10]
                next_state = tlic_pkg::ST_RUN;
            end
            default: begin
                next_state = tlic_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state           <= tlic_pkg::ST_RUN;
            pend_vec        <= `TLIC_VEC_HIGH;
            STACK_PUSH      <= 1'b0;
            STACK_PUSH_ADDR <= '0;
            VECTOR_LOAD     <= 1'b0;
            VECTOR_ADDR     <= '0;
            IRQ_CONTROL_REG <= `TLIC_CTRL_RST;
            HIGH_ACTIVE     <= 1'b0;
            LOW_ACTIVE      <= 1'b0;
        end else begin
            state           <= next_state;
            pend_vec        <= next_pend_vec;
            STACK_PUSH      <= next_push.strobe;
            STACK_PUSH_ADDR <= next_push.addr;
            VECTOR_LOAD     <= next_load.strobe;
            VECTOR_ADDR     <= next_load.addr;
            IRQ_CONTROL_REG <= next_ctrl;
            HIGH_ACTIVE     <= next_hi_act;
            LOW_ACTIVE      <= next_lo_act;
        end
    end

    // Checks
    vec_values_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        VECTOR_LOAD |-> VECTOR_ADDR == `TLIC_VEC_HIGH        // [R01]
                     || VECTOR_ADDR == `TLIC_VEC_LOW)
        else $error("vector address not a vector");
    push_then_load_a: assert property (@(posedge CLK) // [R10]
        disable iff (SYS_RST)
        STACK_PUSH |-> !VECTOR_LOAD ##1 VECTOR_LOAD)
        else $error("load did not follow push");
    take_now_a: assert property (@(posedge CLK) // [R06]
        disable iff (SYS_RST)
        state == tlic_pkg::ST_RUN && (take_hi || take_lo || take_c)
        |=> STACK_PUSH ##1 VECTOR_LOAD && VECTOR_ADDR == $past(pend_vec))
        else $error("eligible request not taken");
    high_first_a: assert property (@(posedge CLK) // [R19]
        disable iff (SYS_RST)
        state == tlic_pkg::ST_RUN && prio_en && gh && gl && hi_any && lo_any
        |=> ##1 VECTOR_ADDR == `TLIC_VEC_HIGH)
        else $error("low taken before high");
    compat_vec_a: assert property (@(posedge CLK) // [R07]
        disable iff (SYS_RST)
        state == tlic_pkg::ST_RUN && take_c
        |=> !IRQ_CONTROL_REG[`TLIC_GH_BIT] ##1 VECTOR_ADDR == `TLIC_VEC_HIGH)
        else $error("compatibility vector wrong");
    low_clear_a: assert property (@(posedge CLK) // [R08]
        disable iff (SYS_RST)
        state == tlic_pkg::ST_RUN && take_lo && !CTRL_WR
        |=> !IRQ_CONTROL_REG[`TLIC_GL_BIT] && LOW_ACTIVE)
        else $error("low enable not cleared");
    low_wait_a: assert property (@(posedge CLK) // [R09]
        disable iff (SYS_RST)
        HIGH_ACTIVE && prio_en && !hi_any && state == tlic_pkg::ST_RUN
        |=> !STACK_PUSH)
        else $error("low serviced during high handler");
    ret_sets_a: assert property (@(posedge CLK) // [R12]
        disable iff (SYS_RST)
        state == tlic_pkg::ST_RUN && RETURN_FROM_IRQ_OP && !take_hi
        && !take_lo && !take_c && !CTRL_WR && !(prio_en && LOW_ACTIVE)
        |=> IRQ_CONTROL_REG[`TLIC_GH_BIT] && !HIGH_ACTIVE)
        else $error("return did not re-enable");
    flag_sticky_a: assert property (@(posedge CLK) // [R14]
        disable iff (SYS_RST)
        tmr_ovf |=> PERIPHERAL_FLAG_REG_A[`TLIC_TMR_FLAG])
        else $error("overflow flag not set");
    ext_latency_a: assert property (@(posedge CLK) // [R13]
        disable iff (SYS_RST)
        EXTERNAL_IRQ_PINS[0] && !$past(EXTERNAL_IRQ_PINS[0]) && !prio_en
        && gh && EXT_ENABLE[0] && !EXT_FLAGS[0] && !CTRL_WR
        && state == tlic_pkg::ST_RUN && !STACK_PUSH
        |-> ##[1:3] STACK_PUSH ##1 VECTOR_LOAD)
        else $error("external latency too long");
    ret_low_a: assert property (@(posedge CLK) // [R12]
        disable iff (SYS_RST)
        state == tlic_pkg::ST_RUN && RETURN_FROM_IRQ_OP && prio_en
        && !take_hi && !take_lo && LOW_ACTIVE && !HIGH_ACTIVE && !CTRL_WR
        |=> IRQ_CONTROL_REG[`TLIC_GL_BIT] && !LOW_ACTIVE)
        else $error("return did not re-enable low group");
    group_gate_a: assert property (@(posedge CLK) // [R05]
        disable iff (SYS_RST)
        prio_en && !gh && !gl |=> !STACK_PUSH)
        else $error("request taken with both groups disabled");
    ext_flag_a: assert property (@(posedge CLK) // [R14]
        disable iff (SYS_RST)
        ext_rise[0] |=> EXT_FLAGS[0])
        else $error("external flag not set");
    tmr_gate_a: assert property (@(posedge CLK) // [R17]
        disable iff (SYS_RST)
        !PERIPHERAL_ENABLE_REG_A[`TLIC_TMR_FLAG] && EXT_FLAGS == 3'h0
        && PERIPHERAL_FLAG_REG_A == 8'h01 |=> !STACK_PUSH)
        else $error("disabled timer request taken");
    tmr_wrap_a: assert property (@(posedge CLK) // [R16]
        disable iff (SYS_RST)
        tmr_ovf |-> TIMER_COUNT == `TLIC_TMR_RST)
        else $error("overflow without wrap");

    preempt_c: cover property (@(posedge CLK) disable iff (SYS_RST)
        LOW_ACTIVE && STACK_PUSH && pend_vec == `TLIC_VEC_HIGH);
    compat_c: cover property (@(posedge CLK) disable iff (SYS_RST)
        !prio_en && VECTOR_LOAD);
    low_c: cover property (@(posedge CLK) disable iff (SYS_RST)
        VECTOR_LOAD && VECTOR_ADDR == `TLIC_VEC_LOW);
    ret_low_c: cover property (@(posedge CLK) disable iff (SYS_RST)
        RETURN_FROM_IRQ_OP && LOW_ACTIVE && !HIGH_ACTIVE);
    ext_vec_c: cover property (@(posedge CLK) disable iff (SYS_RST)
        STACK_PUSH && EXT_FLAGS != 3'h0);
endmodule : tlic_top

// *** test/tlic_core_model.sv ***
/*
 * Core sequencer model: runs a program counter, keeps a return stack
 * and issues the return op on bench request.
 * Assumes the controller's push and load strobes on consecutive clocks.
 */
`timescale 1ns/1ns
`include "tlic_defs.svh"

module tlic_core_model (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Controller side
    input  wire logic                    push,
    input  wire logic [`TLIC_ADDR_W-1:0] push_addr,
    input  wire logic                    load,
    input  wire logic [`TLIC_ADDR_W-1:0] vec_addr,
    output logic                         ret_op,
    output logic      [`TLIC_ADDR_W-1:0] ret_addr,
    // Bench side
    input  wire logic                    ret_req,
    output logic                         order_err
);
    logic [`TLIC_ADDR_W-1:0] stack [0:31];
    logic [4:0]              sp;
    logic                    push_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ret_addr <= 21'h000100;
            sp <= 5'h00;
            ret_op <= 1'b0;
            push_d <= 1'b0;
            order_err <= 1'b0;
        end else begin
            push_d <= push;
            ret_op <= ret_req;
            ret_addr <= ret_addr + 21'h000001;
            if (push) begin
                stack[sp] <= push_addr;
                sp <= sp + 5'h01;
            end
            if (load) begin
                ret_addr <= vec_addr;
                order_err <= order_err | !push_d;
            end
            if (ret_req) begin
                ret_addr <= stack[sp-5'h01];
                sp <= sp - 5'h01;
            end
        end
    end
endmodule : tlic_core_model

// *** test/tb_tlic_top.sv ***
/*
 * Bench for the interrupt controller: call sequences with expected values.
 * Assumes the core model drives the return op and return address.
 */
`timescale 1ns/1ns
`include "tlic_defs.svh"

module tb_tlic_top;
    logic                    clk, rst, cwr, twr, trun, cm, ret_req;
    logic                    ret_op, push, vload, hact, lact, oerr;
    logic [7:0]              rcr, cwd, irq, pclr, pen, ppr, pflag;
    logic [7:1]              pev;
    logic [2:0]              pins, eclr, een, epr, eflag;
    logic [15:0]             twd, tcnt;
    logic [3:0]              cms;
    logic [`TLIC_ADDR_W-1:0] ret_addr, paddr, vaddr;
    int                      err_count, checked, n;

    tlic_top i_dut (
        .CLK(clk), .SYS_RST(rst), .RESET_CONTROL_REG(rcr),
        .CTRL_WR(cwr), .CTRL_WDATA(cwd), .IRQ_CONTROL_REG(irq),
        .PERIPH_EVENT(pev), .PERIPH_FLAG_CLR(pclr),
        .PERIPHERAL_ENABLE_REG_A(pen), .PERIPHERAL_PRIORITY_REG_A(ppr),
        .PERIPHERAL_FLAG_REG_A(pflag), .EXTERNAL_IRQ_PINS(pins),
        .EXT_FLAG_CLR(eclr), .EXT_ENABLE(een), .EXT_PRIORITY(epr),
        .EXT_FLAGS(eflag), .TIMER_RUN(trun), .TIMER_WR(twr),
        .TIMER_WDATA(twd), .COMPARE_MODE_SELECT(cms),
        .COMPARE_MATCH(cm), .TIMER_COUNT(tcnt),
        .RETURN_FROM_IRQ_OP(ret_op), .CORE_RET_ADDR(ret_addr),
        .STACK_PUSH(push), .STACK_PUSH_ADDR(paddr), .VECTOR_LOAD(vload),
        .VECTOR_ADDR(vaddr), .HIGH_ACTIVE(hact), .LOW_ACTIVE(lact)
    );

    tlic_core_model i_core (
        .clk(clk), .rst(rst), .push(push), .push_addr(paddr),
        .load(vload), .vec_addr(vaddr), .ret_op(ret_op),
        .ret_addr(ret_addr), .ret_req(ret_req), .order_err(oerr)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string nm, input logic [20:0] e, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            err_count++;
            $display("[FAIL] wait expected %0d got %0d", lim, k);
            wrap_up();
        end
    endtask : guard

    task automatic rst_dut();
        {rcr, cwr, cwd, pev, pclr, pen, ppr} = '0;
        {pins, eclr, een, epr, trun, twr, twd, cms, cm, ret_req} = '0;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
    endtask : rst_dut

    task automatic ev(input int i);
        pev[i] = 1'b1;
        tick(1);
        pev = '0;
    endtask : ev

    task automatic ctl(input logic [7:0] v);
        cwd = v;
        cwr = 1'b1;
        tick(1);
        cwr = 1'b0;
    endtask : ctl

    task automatic clr(input logic [7:0] m);
        pclr = m;
        tick(1);
        pclr = '0;
    endtask : clr

    task automatic ret();
        ret_req = 1'b1;
        tick(1);
        ret_req = 1'b0;
        tick(1);
    endtask : ret

    task automatic no_vec(input int k);
        repeat (k) begin
            tick(1);
            chk("no_push", 1'b0, push);
        end
    endtask : no_vec

    task automatic wait_vec(input logic [20:0] e);
        logic [20:0] ra;
        int          k;
        k = 0;
        ra = ret_addr;
        while (push !== 1'b1 && k < 20) begin
            ra = ret_addr;
            tick(1);
            k++;
        end
        guard(k, 20);
        chk("push_addr", ra, paddr);
        tick(1);
        chk("vec_load", 1'b1, vload);
        chk("vec_addr", e, vaddr);
    endtask : wait_vec

    initial begin
        err_count = 0;
        checked = 0;
        rst_dut();
        chk("ctl_rst", 8'h00, irq);
        chk("flag_rst", 8'h00, pflag);
        chk("tmr_rst", 16'h0000, tcnt);
        ev(3);
        chk("flag_set", 8'h08, pflag);
        no_vec(3);
        clr(8'h08);
        chk("flag_clr", 8'h00, pflag);
        pins = 3'h1;
        tick(2);
        chk("ext_flag", 3'h1, eflag);
        $display("test flags done");

        rst_dut();
        ctl(8'hC0);
        pen = 8'h08;
        ev(3);
        wait_vec(`TLIC_VEC_HIGH);
        chk("ctl_acc", 8'h40, irq);
        chk("hi_act", 1'b1, hact);
        clr(8'h08);
        ret();
        chk("ctl_ret", 8'hC0, irq);
        chk("hi_done", 1'b0, hact);
        ctl(8'h80);
        ev(3);
        no_vec(3);
        een = 3'h1;
        pins = 3'h1;
        n = 0;
        while (vload !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        guard(n, 10);
        chk("ext_lat", 1'b1, n >= 3 && n <= 4);
        chk("ext_vec", `TLIC_VEC_HIGH, vaddr);
        $display("test compat done");

        rst_dut();
        rcr = 8'h80;
        ctl(8'h40);
        pen = 8'h18;
        ppr = 8'h10;
        ev(4);
        no_vec(3);
        ev(3);
        wait_vec(`TLIC_VEC_LOW);
        chk("ctl_low", 8'h00, irq);
        ctl(8'h80);
        wait_vec(`TLIC_VEC_HIGH);
        chk("ctl_high", 8'h00, irq);
        chk("both_act", 2'h3, {hact, lact});
        clr(8'h10);
        ctl(8'h40);
        no_vec(4);
        ret();
        chk("ctl_ret", 8'hC0, irq);
        wait_vec(`TLIC_VEC_LOW);
        chk("ctl_low2", 8'h80, irq);
        clr(8'h08);
        ret();
        chk("ctl_ret2", 8'hC0, irq);
        chk("lo_done", 2'h0, {hact, lact});
        $display("test priority done");

        rst_dut();
        rcr = 8'h80;
        ctl(8'hC0);
        pen = 8'h18;
        ppr = 8'h10;
        pev[3] = 1'b1;
        pev[4] = 1'b1;
        tick(1);
        pev = '0;
        wait_vec(`TLIC_VEC_HIGH);
        chk("ctl_tie", 8'h40, irq);
        $display("test tie done");

        rst_dut();
        twd = 16'hFFFE;
        twr = 1'b1;
        tick(1);
        twr = 1'b0;
        chk("tmr_load", 16'hFFFE, tcnt);
        trun = 1'b1;
        tick(2);
        trun = 1'b0;
        chk("tmr_wrap", 16'h0000, tcnt);
        tick(1);
        chk("tmr_flag", 8'h01, pflag);
        ctl(8'hC0);
        no_vec(2);
        pen = 8'h01;
        wait_vec(`TLIC_VEC_HIGH);
        clr(8'h01);
        twd = 16'h1234;
        twr = 1'b1;
        tick(1);
        twr = 1'b0;
        cms = 4'hB;
        cm = 1'b1;
        tick(1);
        cm = 1'b0;
        chk("cmp_rst", 16'h0000, tcnt);
        tick(1);
        chk("cmp_flag", 8'h00, pflag);
        twd = 16'h5678;
        twr = 1'b1;
        cm = 1'b1;
        tick(1);
        {twr, cm} = 2'h0;
        chk("wr_wins", 16'h5678, tcnt);
        cms = 4'hA;
        cm = 1'b1;
        tick(1);
        cm = 1'b0;
        chk("cmp_mode", 16'h5678, tcnt);
        chk("order", 1'b0, oerr);
        $display("test timer done");
        wrap_up();
    end
endmodule : tb_tlic_top
